/* inc/stsc_pkg.sv */
package stsc_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int AXIS_W = 12;
   localparam int WORD_W = 16;
   localparam int FIFO_WORDS = 8;
   localparam int ODR_W = 3;
   localparam int TICK_CNT_W = 24;

   // Register offsets and the soft reset code
   localparam logic [ADDR_W-1:0] REG_REVISION = 8'h03;
   localparam logic [ADDR_W-1:0] REG_FIFO_CONTROL = 8'h3A;
   localparam logic [ADDR_W-1:0] REG_SAMPLE_RATE_CONTROL = 8'h3D;
   localparam logic [ADDR_W-1:0] REG_POWER_CONTROL = 8'h3F;
   localparam logic [ADDR_W-1:0] REG_SOFT_RESET = 8'h41;
   localparam logic [ADDR_W-1:0] REG_FIFO_ACCESS = 8'h42;
   localparam logic [DATA_W-1:0] SOFT_RESET_CODE = 8'h52;

   // Field layout of sample_rate_control, power and FIFO control
   localparam int EXTERNAL_SYNC_SELECT_BIT = 0;
   localparam int EXTERNAL_CLOCK_SELECT_BIT = 1;
   localparam int ODR_LSB = 5;
   localparam int MODE_LSB = 0;
   localparam int FIFO_MODE_LSB = 0;

   localparam logic [DATA_W-1:0] RATE_RESET = 8'h00;
   localparam logic [DATA_W-1:0] POWER_RESET = 8'h00;
   localparam logic [DATA_W-1:0] FIFO_CTL_RESET = 8'h00;
   localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;

   // Timebase: one tick per period at the highest output data rate
   localparam int CLK_PERIOD_NS = 25;
   localparam int BASE_PERIOD_NS = 390625;
   localparam int BASE_TICK_CYCLES = BASE_PERIOD_NS / CLK_PERIOD_NS;

   typedef enum logic [1:0] {
      MODE_STANDBY = 2'b00,
      MODE_WAKE_UP = 2'b01,
      MODE_INSTANT_ON = 2'b10,
      MODE_MEASURE = 2'b11
   } stsc_mode_t;

   typedef enum logic [1:0] {
      FIFO_BYPASS = 2'b00,
      FIFO_STORE = 2'b01,
      FIFO_STORE_ALT = 2'b10,
      FIFO_STORE_ALT2 = 2'b11
   } stsc_fifo_mode_t;

   typedef enum logic [3:0] {
      SEQ_IDLE = 4'b0001,
      SEQ_X = 4'b0010,
      SEQ_Y = 4'b0100,
      SEQ_Z = 4'b1000
   } stsc_seq_t;

   localparam logic [1:0] AXIS_X_CODE = 2'h0;
   localparam logic [1:0] AXIS_Y_CODE = 2'h1;
   localparam logic [1:0] AXIS_Z_CODE = 2'h2;
endpackage

/* verilog/stsc_fifo.sv */
`timescale 1ns/1ps
module stsc_fifo
   import stsc_pkg::*;
#(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
)
(
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic flush_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o,
   output logic full_o
);
   localparam int PTR_W = $clog2(DEPTH);
   localparam logic [PTR_W:0] DEPTH_C = (PTR_W + 1)'(DEPTH);
   localparam logic [PTR_W-1:0] LAST_C = (PTR_W)'(DEPTH - 1);

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [PTR_W-1:0] wr_ptr_r, wr_ptr_nxt, rd_ptr_r, rd_ptr_nxt;
   logic [PTR_W:0] count_r, count_nxt;
   logic push, pop;

   assign in_ready_o = (count_r != DEPTH_C) && !flush_i;
   assign out_valid_o = (count_r != '0) && !flush_i;
   assign full_o = (count_r == DEPTH_C);
   assign out_data_o = mem_r[rd_ptr_r];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;

   always_comb
   begin
      wr_ptr_nxt = wr_ptr_r;
      rd_ptr_nxt = rd_ptr_r;
      count_nxt = count_r;
      if (flush_i)
      begin
         wr_ptr_nxt = '0;
         rd_ptr_nxt = '0;
         count_nxt = '0;
      end
      else
      begin
         if (push)
            wr_ptr_nxt = (wr_ptr_r == LAST_C) ? '0 : wr_ptr_r + 1'b1;
         if (pop)
            rd_ptr_nxt = (rd_ptr_r == LAST_C) ? '0 : rd_ptr_r + 1'b1;
         if (push && !pop)
            count_nxt = count_r + 1'b1;
         else if (pop && !push)
            count_nxt = count_r - 1'b1;
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r <= '0;
      end
      else
      begin
         wr_ptr_r <= wr_ptr_nxt;
         rd_ptr_r <= rd_ptr_nxt;
         count_r <= count_nxt;
      end
   end

   // Storage has no reset; only the pointers and the count define what is valid
   always_ff @(posedge clk_i)
   begin
      if (push)
         mem_r[wr_ptr_r] <= in_data_i;
   end
endmodule

/* verilog/stsc_sample_timing.sv */
`timescale 1ns/1ps
module stsc_sample_timing
   import stsc_pkg::*;
#(
   parameter int TICK_CYCLES = BASE_TICK_CYCLES,
   // Arbitrary neutral value
   parameter logic [DATA_W-1:0] SILICON_REVISION_CODE = 8'h5A
)
(
   input wire logic CLK_I,
   input wire logic RESETN_I,
   input wire logic REG_WR_I,
   input wire logic REG_RD_I,
   input wire logic [ADDR_W-1:0] REG_ADDR_I,
   input wire logic [DATA_W-1:0] REG_WDATA_I,
   output logic [DATA_W-1:0] REG_RDATA_O,
   input wire logic EVENT_PIN_A_I,
   output logic EVENT_PIN_A_O,
   output logic EVENT_PIN_A_OE_N_O,
   input wire logic EVENT_PIN_B_I,
   input wire logic [AXIS_W-1:0] SENSE_X_I,
   input wire logic [AXIS_W-1:0] SENSE_Y_I,
   input wire logic [AXIS_W-1:0] SENSE_Z_I,
   output logic CONVERTER_ON_O,
   output logic FIFO_FULL_O
);
   localparam logic [TICK_CNT_W-1:0] TICK_LAST = TICK_CNT_W'(TICK_CYCLES - 1);

   logic [DATA_W-1:0] rate_r, rate_nxt, power_r, power_nxt, fifo_ctl_r, fifo_ctl_nxt;
   logic [DATA_W-1:0] rdata_r, rdata_nxt;
   logic [2:0] pin_a_r, pin_b_r;
   logic [TICK_CNT_W-1:0] pre_cnt_r, pre_cnt_nxt;
   logic [7:0] odr_cnt_r, odr_cnt_nxt;
   logic byte_phase_r, byte_phase_nxt;
   logic [WORD_W-1:0] held_word_r, held_word_nxt;
   logic [3*AXIS_W-1:0] capture_r, capture_nxt;
   stsc_seq_t seq_r, seq_nxt;

   logic external_sync_select, external_clock_select, sampling, base_tick, odr_tick, start, pin_a_rise, pin_b_rise;
   logic soft_reset, flush, rd_fifo, wr_valid, wr_ready, rd_valid, rd_ready, fifo_full;
   logic [WORD_W-1:0] wr_word, rd_word;
   logic [7:0] odr_last;
   stsc_mode_t mode;
   stsc_fifo_mode_t fifo_mode;

   // Pins are foreign to CLK_I: stage 0 only feeds stage 1
   always_ff @(posedge CLK_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
      begin
         pin_a_r <= '0;
         pin_b_r <= '0;
      end
      else
      begin
         pin_a_r <= {pin_a_r[1:0], EVENT_PIN_A_I};
         pin_b_r <= {pin_b_r[1:0], EVENT_PIN_B_I};
      end
   end
   assign pin_a_rise = pin_a_r[1] && !pin_a_r[2];
   assign pin_b_rise = pin_b_r[1] && !pin_b_r[2];

   assign external_sync_select = rate_r[EXTERNAL_SYNC_SELECT_BIT];
   assign external_clock_select = rate_r[EXTERNAL_CLOCK_SELECT_BIT];
   assign mode = stsc_mode_t'(power_r[MODE_LSB +: 2]);
   assign fifo_mode = stsc_fifo_mode_t'(fifo_ctl_r[FIFO_MODE_LSB +: 2]);
   assign odr_last = 8'((9'h001 << rate_r[ODR_LSB +: ODR_W]) - 9'h001);

   // Instant-on and standby do not stream samples into the FIFO
   always_comb
   begin
      unique case (mode)
         MODE_MEASURE: sampling = 1'b1;
         MODE_WAKE_UP: sampling = 1'b1;
         MODE_INSTANT_ON: sampling = 1'b0;
         MODE_STANDBY: sampling = 1'b0;
      endcase
   end

   // The timebase advances on pin A edges when the external clock is chosen
   assign base_tick = external_clock_select ? pin_a_rise : (pre_cnt_r == TICK_LAST);
   assign odr_tick = base_tick && (odr_cnt_r == odr_last);
   // With external sync the internal rate never starts a conversion
   assign start = sampling && (seq_r == SEQ_IDLE) && (external_sync_select ? pin_b_rise : odr_tick);
   assign CONVERTER_ON_O = (seq_r != SEQ_IDLE);

   assign soft_reset = REG_WR_I && (REG_ADDR_I == REG_SOFT_RESET) && (REG_WDATA_I == SOFT_RESET_CODE);
   assign flush = (fifo_mode == FIFO_BYPASS) || soft_reset;
   assign rd_fifo = REG_RD_I && (REG_ADDR_I == REG_FIFO_ACCESS);
   assign rd_ready = rd_fifo && !byte_phase_r;

   always_comb
   begin
      pre_cnt_nxt = (external_clock_select || pre_cnt_r == TICK_LAST) ? '0 : pre_cnt_r + 1'b1;
      odr_cnt_nxt = odr_cnt_r;
      if (base_tick)
         odr_cnt_nxt = (odr_cnt_r >= odr_last) ? '0 : odr_cnt_r + 1'b1;
   end

   // Sample set sequencer; a trigger while busy is not queued
   always_comb
   begin
      seq_nxt = seq_r;
      capture_nxt = capture_r;
      wr_valid = 1'b0;
      wr_word = '0;
      unique case (seq_r)
         SEQ_IDLE:
         begin
            if (start)
            begin
               capture_nxt = {SENSE_Z_I, SENSE_Y_I, SENSE_X_I};
               seq_nxt = SEQ_X;
            end
         end
         SEQ_X:
         begin
            wr_valid = 1'b1;
            wr_word = {capture_r[0 +: AXIS_W], 2'b00, AXIS_X_CODE};
            if (wr_ready)
               seq_nxt = SEQ_Y;
         end
         SEQ_Y:
         begin
            wr_valid = 1'b1;
            wr_word = {capture_r[AXIS_W +: AXIS_W], 2'b00, AXIS_Y_CODE};
            if (wr_ready)
               seq_nxt = SEQ_Z;
         end
         SEQ_Z:
         begin
            wr_valid = 1'b1;
            wr_word = {capture_r[2*AXIS_W +: AXIS_W], 2'b00, AXIS_Z_CODE};
            if (wr_ready)
               seq_nxt = SEQ_IDLE;
         end
         default:
            seq_nxt = SEQ_IDLE;
      endcase
      // A flush aborts a partial set so the next set starts again at x
      if (flush)
      begin
         seq_nxt = SEQ_IDLE;
         wr_valid = 1'b0;
      end
   end

   // Register writes
   always_comb
   begin
      rate_nxt = rate_r;
      power_nxt = power_r;
      fifo_ctl_nxt = fifo_ctl_r;
      if (soft_reset)
      begin
         rate_nxt = RATE_RESET;
         power_nxt = POWER_RESET;
         fifo_ctl_nxt = FIFO_CTL_RESET;
      end
      else if (REG_WR_I)
      begin
         if (REG_ADDR_I == REG_SAMPLE_RATE_CONTROL)
            rate_nxt = REG_WDATA_I;
         if (REG_ADDR_I == REG_POWER_CONTROL)
            power_nxt = REG_WDATA_I;
         if (REG_ADDR_I == REG_FIFO_CONTROL)
            fifo_ctl_nxt = REG_WDATA_I;
      end
   end

   // Register reads; an empty FIFO reads as zero and does not advance the byte phase
   always_comb
   begin
      rdata_nxt = rdata_r;
      byte_phase_nxt = byte_phase_r;
      held_word_nxt = held_word_r;
      if (flush)
         byte_phase_nxt = 1'b0;
      if (REG_RD_I)
      begin
         unique case (REG_ADDR_I)
            REG_REVISION: rdata_nxt = SILICON_REVISION_CODE;
            REG_SAMPLE_RATE_CONTROL: rdata_nxt = rate_r;
            REG_POWER_CONTROL: rdata_nxt = power_r;
            REG_FIFO_CONTROL: rdata_nxt = fifo_ctl_r;
            REG_FIFO_ACCESS:
            begin
               if (byte_phase_r)
               begin
                  rdata_nxt = held_word_r[DATA_W-1:0];
                  byte_phase_nxt = 1'b0;
               end
               else if (rd_valid)
               begin
                  rdata_nxt = rd_word[WORD_W-1:DATA_W];
                  held_word_nxt = rd_word;
                  byte_phase_nxt = 1'b1;
               end
               else
                  rdata_nxt = ZERO_BYTE;
            end
            default: rdata_nxt = ZERO_BYTE;
         endcase
      end
   end

   always_ff @(posedge CLK_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
      begin
         rate_r <= RATE_RESET;
         power_r <= POWER_RESET;
         fifo_ctl_r <= FIFO_CTL_RESET;
         rdata_r <= ZERO_BYTE;
         pre_cnt_r <= '0;
         odr_cnt_r <= '0;
         byte_phase_r <= 1'b0;
         held_word_r <= '0;
         capture_r <= '0;
         seq_r <= SEQ_IDLE;
      end
      else
      begin
         rate_r <= rate_nxt;
         power_r <= power_nxt;
         fifo_ctl_r <= fifo_ctl_nxt;
         rdata_r <= rdata_nxt;
         pre_cnt_r <= pre_cnt_nxt;
         odr_cnt_r <= odr_cnt_nxt;
         byte_phase_r <= byte_phase_nxt;
         held_word_r <= held_word_nxt;
         capture_r <= capture_nxt;
         seq_r <= seq_nxt;
      end
   end

   // Full FIFO stalls the sequencer rather than splitting a set
   stsc_fifo #(
      .WIDTH(WORD_W),
      .DEPTH(FIFO_WORDS)
   ) u_fifo (
      .clk_i(CLK_I),
      .resetn_i(RESETN_I),
      .flush_i(flush),
      .in_valid_i(wr_valid),
      .in_ready_o(wr_ready),
      .in_data_i(wr_word),
      .out_valid_o(rd_valid),
      .out_ready_i(rd_ready),
      .out_data_o(rd_word),
      .full_o(fifo_full)
   );

   logic full_q_r;
   always_ff @(posedge CLK_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
         full_q_r <= 1'b0;
      else
         full_q_r <= fifo_full;
   end

   // Pin A is an input while it carries the external clock
   assign EVENT_PIN_A_O = full_q_r;
   assign EVENT_PIN_A_OE_N_O = external_clock_select;
   assign FIFO_FULL_O = full_q_r;
   assign REG_RDATA_O = rdata_r;
endmodule

/* testbench/stsc_sample_timing_sva.sv */
`timescale 1ns/1ps
module stsc_sample_timing_chk
   import stsc_pkg::*;
(
   input wire logic CLK_I,
   input wire logic RESETN_I,
   input wire logic REG_WR_I,
   input wire logic REG_RD_I,
   input wire logic [ADDR_W-1:0] REG_ADDR_I,
   input wire logic [DATA_W-1:0] REG_WDATA_I,
   input wire logic [DATA_W-1:0] REG_RDATA_O,
   input wire logic EVENT_PIN_A_O,
   input wire logic EVENT_PIN_A_OE_N_O,
   input wire logic EVENT_PIN_B_I,
   input wire logic CONVERTER_ON_O,
   input wire logic FIFO_FULL_O
);
   logic [7:0] rate_r, rate_nxt, pwr_r, pwr_nxt;
   logic unmap;
   assign unmap = !(REG_ADDR_I inside {REG_REVISION, REG_FIFO_CONTROL, REG_SAMPLE_RATE_CONTROL,
      REG_POWER_CONTROL, REG_SOFT_RESET, REG_FIFO_ACCESS});
   // Shadows of the sample rate and power control registers, rebuilt from the write strobes
   always_comb
   begin
      rate_nxt = rate_r;
      pwr_nxt = pwr_r;
      if (REG_WR_I && REG_ADDR_I == REG_SAMPLE_RATE_CONTROL)
         rate_nxt = REG_WDATA_I;
      if (REG_WR_I && REG_ADDR_I == REG_POWER_CONTROL)
         pwr_nxt = REG_WDATA_I;
      if (REG_WR_I && REG_ADDR_I == REG_SOFT_RESET && REG_WDATA_I == SOFT_RESET_CODE)
      begin
         rate_nxt = RATE_RESET;
         pwr_nxt = POWER_RESET;
      end
   end
   always_ff @(posedge CLK_I or negedge RESETN_I)
      if (!RESETN_I)
         {rate_r, pwr_r} <= '0;
      else
         {rate_r, pwr_r} <= {rate_nxt, pwr_nxt};
   default clocking cb @(posedge CLK_I);
   endclocking
   default disable iff (!RESETN_I);
   set_len_a: assert property ($rose(CONVERTER_ON_O) |-> CONVERTER_ON_O[*3])
      else $error("sample set shorter than three words");
   no_trig_a: assert property ((rate_r[EXTERNAL_SYNC_SELECT_BIT] && !EVENT_PIN_B_I)[*6] |=> !$rose(CONVERTER_ON_O))
      else $error("conversion without trigger");
   idle_mode_a: assert property ((!pwr_r[MODE_LSB])[*4] |=> !$rose(CONVERTER_ON_O))
      else $error("conversion in a non sampling mode");
   pin_dir_a: assert property (EVENT_PIN_A_OE_N_O == rate_r[EXTERNAL_CLOCK_SELECT_BIT])
      else $error("pin A direction wrong");
   full_flag_a: assert property (!EVENT_PIN_A_OE_N_O |-> EVENT_PIN_A_O == FIFO_FULL_O)
      else $error("pin A does not show FIFO full");
   rd_hold_a: assert property (!REG_RD_I && !REG_WR_I |=> $stable(REG_RDATA_O))
      else $error("read data moved without a read");
   unmapped_zero_a: assert property (REG_RD_I && unmap |=> REG_RDATA_O == ZERO_BYTE)
      else $error("unmapped read not zero");
   rate_rb_a: assert property (REG_RD_I && !REG_WR_I && REG_ADDR_I == REG_SAMPLE_RATE_CONTROL
      |=> REG_RDATA_O == $past(rate_r))
      else $error("rate control readback wrong");
   cover property ($rose(CONVERTER_ON_O));
   cover property ($rose(FIFO_FULL_O));
   cover property (REG_RD_I && REG_ADDR_I == REG_FIFO_ACCESS);
endmodule
bind stsc_sample_timing stsc_sample_timing_chk u_chk (.CLK_I(CLK_I), .RESETN_I(RESETN_I),
   .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I), .REG_ADDR_I(REG_ADDR_I),
   .REG_WDATA_I(REG_WDATA_I), .REG_RDATA_O(REG_RDATA_O), .EVENT_PIN_A_O(EVENT_PIN_A_O),
   .EVENT_PIN_A_OE_N_O(EVENT_PIN_A_OE_N_O), .EVENT_PIN_B_I(EVENT_PIN_B_I),
   .CONVERTER_ON_O(CONVERTER_ON_O), .FIFO_FULL_O(FIFO_FULL_O));

/* testbench/stsc_host_model.sv */
`timescale 1ns/1ps
module stsc_host_model
(
   input wire logic clk_i,
   input wire logic trig_i,
   input wire logic run_clk_i,
   output logic pin_a_o,
   output logic pin_b_o
);
   logic [2:0] cnt = '0;
   logic [3:0] sh = '0;
   always @(posedge clk_i)
   begin
      cnt <= cnt + 3'h1;
      // Clock stands still low when not running, never a stray edge
      pin_a_o <= run_clk_i && cnt[2];
      sh <= {sh[2:0], trig_i};
      pin_b_o <= |sh;
   end
endmodule

/* testbench/stsc_sample_timing_tb_top.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_errors++; \
   $display("unexpected at %0t: %h vs %h", $time, a, b); end end
module stsc_sample_timing_tb_top
   import stsc_pkg::*;
();
   localparam logic [7:0] REV = 8'h5A; // Arbitrary value
   localparam logic [7:0] RC = REG_SAMPLE_RATE_CONTROL;
   localparam logic [7:0] FC = REG_FIFO_CONTROL;
   logic clk, rstn, wr, rd, trig, run, a_o, a_oe_n, h_a, h_b, conv, full;
   logic [7:0] addr, wdata, rdata, hi, lo, r;
   logic [11:0] sx, sy, sz;
   logic [15:0] q[$];
   wire pin_a = a_oe_n ? h_a : a_o;
   int n_errors, checks, k;
   stsc_sample_timing #(.TICK_CYCLES(8), .SILICON_REVISION_CODE(REV)) dut (.CLK_I(clk),
      .RESETN_I(rstn), .REG_WR_I(wr), .REG_RD_I(rd), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
      .REG_RDATA_O(rdata), .EVENT_PIN_A_I(pin_a), .EVENT_PIN_A_O(a_o),
      .EVENT_PIN_A_OE_N_O(a_oe_n), .EVENT_PIN_B_I(h_b), .SENSE_X_I(sx), .SENSE_Y_I(sy),
      .SENSE_Z_I(sz), .CONVERTER_ON_O(conv), .FIFO_FULL_O(full));
   stsc_host_model host (.clk_i(clk), .trig_i(trig), .run_clk_i(run), .pin_a_o(h_a),
      .pin_b_o(h_b));
   task automatic wreg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rreg(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   // Model: one queue of expected words, an empty FIFO reads as zero
   task automatic rw;
      logic [15:0] e;
      rreg(REG_FIFO_ACCESS, hi);
      rreg(REG_FIFO_ACCESS, lo);
      e = q.size() ? q.pop_front() : 16'h0000;
      `CHK({hi, lo}, e)
   endtask
   task automatic push_set;
      q.push_back({sx, 2'b00, AXIS_X_CODE});
      q.push_back({sy, 2'b00, AXIS_Y_CODE});
      q.push_back({sz, 2'b00, AXIS_Z_CODE});
   endtask
   task automatic flush;
      wreg(FC, 8'h00);
      wreg(FC, 8'h01);
      q.delete();
   endtask
   task automatic done(input string s);
      $display("test %s done", s);
   endtask
   task automatic summarize;
      $display("checks %0d errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   initial
   begin
      #(25 * 20000);
      n_errors++;
      summarize();
   end
   initial
   begin
      {rstn, wr, rd, trig, run, addr, wdata} = '0;
      r = 8'($urandom(32'h0000_cd25));
      {sx, sy, sz} = 36'({$urandom, $urandom});
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      wreg(FC, 8'h01);
      wreg(RC, 8'h01);
      wreg(REG_POWER_CONTROL, 8'h03);
      repeat (40) @(posedge clk);
      rw();
      `CHK(conv, 1'b0)
      done("held off");
      wreg(FC, 8'h03);
      @(posedge clk);
      trig <= 1'b1;
      @(posedge clk);
      trig <= 1'b0;
      repeat (20) @(posedge clk);
      push_set();
      repeat (4) rw();
      done("trigger");
      wreg(RC, 8'h00);
      repeat (400) if (full !== 1'b1) @(posedge clk) #1;
      `CHK(full, 1'b1)
      `CHK(conv, 1'b1)
      wreg(RC, 8'h01);
      #1;
      `CHK(a_o, 1'b1)
      // The stalled z lands once the first word is popped
      repeat (3) push_set();
      repeat (9) rw();
      flush();
      rw();
      done("main loop");
      for (k = 0; k < 4; k++)
      begin
         wreg(REG_POWER_CONTROL, 8'(k));
         wreg(RC, 8'h00);
         repeat (20) @(posedge clk);
         wreg(RC, 8'h01);
         if (k[0])
            q.push_back({sx, 2'b00, AXIS_X_CODE});
         rw();
         flush();
      end
      done("modes");
      wreg(FC, 8'h02);
      wreg(RC, 8'h02);
      #1;
      `CHK(a_oe_n, 1'b1)
      repeat (40) @(posedge clk);
      rw();
      @(posedge clk);
      run <= 1'b1;
      repeat (20) @(posedge clk);
      run <= 1'b0;
      wreg(RC, 8'h03);
      q.push_back({sx, 2'b00, AXIS_X_CODE});
      rw();
      flush();
      done("external clock");
      // Standby, so the soft reset below cannot cut a sample set short
      wreg(REG_POWER_CONTROL, 8'h00);
      wreg(RC, r);
      rreg(RC, hi);
      `CHK(hi, r)
      rreg(8'h10, hi);
      `CHK(hi, ZERO_BYTE)
      rreg(REG_REVISION, hi);
      `CHK(hi, REV)
      wreg(REG_SOFT_RESET, SOFT_RESET_CODE);
      rreg(RC, hi);
      `CHK(hi, RATE_RESET)
      done("registers");
      summarize();
   end
endmodule
